// file: hdl/ttm_pkg.sv
package ttm_pkg;
	localparam int NUM_WARN = 6;
	localparam int TEMP_W = 9;
	// Degrees C, integer, unsigned offset-free code from the centre sensor digitiser
	localparam logic [8:0] WARN_THR_C [0:5] = '{9'h050, 9'h05F, 9'h06E, 9'h07D, 9'h08C, 9'h09B};
	localparam logic [8:0] SD_THR_C = 9'h0A5;
	localparam logic [8:0] WARN_HYS_C = 9'h005;
	localparam logic [8:0] SD_HYS_C = 9'h00A;
	// Timing
	localparam int CLK_MHZ = 250;
	localparam int DEBOUNCE_US = 10;
	localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
	localparam int WINDOW_US = 450;
	localparam int WINDOW_CYC = WINDOW_US * CLK_MHZ;
	localparam int INTERVAL_US = 3000;
	localparam int INTERVAL_CYC = INTERVAL_US * CLK_MHZ;
	// Register offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_FLAG = 4'h1;
	localparam logic [3:0] REG_MASK = 4'h2;
	localparam logic [3:0] REG_LIVE = 4'h3;
	localparam logic [3:0] REG_STAT = 4'h4;
	// CTRL fields
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_AON_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [5:0] MASK_RST = 6'h3F;
	// STAT fields
	localparam int STAT_SD_BIT = 0;
	localparam int STAT_PWR_BIT = 1;
	localparam int STAT_EVAL_BIT = 2;
endpackage

// file: hdl/ttm_debounce.sv
`timescale 1ns/1ps
// Passes a comparator level once it held steady for CYC evaluation cycles
module ttm_debounce #(
	parameter int CYC = 2500
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_run,
	input wire logic i_raw,
	output logic o_level
);
	localparam int CW = $clog2(CYC + 1);
	logic [CW-1:0] cnt_r;
	logic level_r;
	wire differs = i_raw != level_r;
	wire done = cnt_r == CW'(CYC - 1);

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_r <= '0;
			level_r <= 1'b0;
		end else if (i_ce && i_run) begin
			// Restart on any bounce; applies in both directions
			cnt_r <= (differs && !done) ? cnt_r + 1'b1 : '0;
			if (differs && done) begin
				level_r <= i_raw;
			end
		end
	end
	assign o_level = level_r;
endmodule

// file: hdl/ttm_monitor.sv
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
// Contract
// - Only the centre-of-die temperature drives warnings and shutdown.
// - Six rising warning thresholds 80..155 C set matching interrupt flags.
// - Each warning has its own latched flag, live level and mask bit.
// - Live level releases only 5 C below its threshold.
// - Shutdown at 165 C, blocked until cooled by shutdown hysteresis.
// - Every comparison debounced 10 us, rising and falling.
// - Monitor enable 0 disables the whole monitor; 1 enables it. Code: 0 stops power and evaluation; flags still drive irq, shutdown holds.
// - Run state: always-on 1 keeps monitor powered, 0 duty-cycles it.
// - Sampling powers monitor 450 us every 3.0 ms, evaluation only then.
// - Standby uses sampling only, while enabled, ignoring always-on.
// - Thresholds 110 to 155 C get the same flag, live, mask bits.
// - Active-low interrupt output low while any unmasked flag set.
module ttm_monitor #(
	parameter int DEBOUNCE_CYC = ttm_pkg::DEBOUNCE_CYC,
	parameter int WINDOW_CYC = ttm_pkg::WINDOW_CYC,
	parameter int INTERVAL_CYC = ttm_pkg::INTERVAL_CYC
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic [ttm_pkg::TEMP_W-1:0] i_centre_temp,
	input wire logic i_standby,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	output logic o_irq_out_n,
	output logic o_sensor_power,
	output logic o_thermal_shutdown
);
	localparam int NW = ttm_pkg::NUM_WARN;
	localparam int TW = ttm_pkg::TEMP_W;
	localparam int SW = $clog2(INTERVAL_CYC + 1);

	logic temp_monitor_enable_r;
	logic temp_monitor_always_on_r;
	logic [NW-1:0] warn_irq_flag_r;
	logic [NW-1:0] warn_irq_mask_r;
	logic [NW-1:0] warn_live_level_r;
	logic [NW-1:0] warn_db_q;
	logic [NW-1:0] warn_db_prev_r;
	logic sd_active_r;
	logic sd_db_q;
	logic [SW-1:0] sched_cnt_r;
	logic [7:0] rdata_r;

	typedef enum logic [1:0] {TTM_OFF, TTM_AON, TTM_SAMPLE} ttm_mode_t;
	ttm_mode_t mode_r;
	ttm_mode_t mode_nxt;

	// Mode choice
	always_comb begin
		mode_nxt = TTM_OFF;
		if (!temp_monitor_enable_r) begin
			mode_nxt = TTM_OFF;
		end else if (i_standby) begin
			mode_nxt = TTM_SAMPLE;
		end else if (temp_monitor_always_on_r) begin
			mode_nxt = TTM_AON;
		end else begin
			mode_nxt = TTM_SAMPLE;
		end
	end

	// Duty-cycle schedule
	wire sched_last = sched_cnt_r == SW'(INTERVAL_CYC - 1);
	wire in_window = sched_cnt_r < SW'(WINDOW_CYC);
	logic evaluate;
	always_comb begin
		case (mode_r)
			TTM_OFF: evaluate = 1'b0;
			TTM_AON: evaluate = 1'b1;
			TTM_SAMPLE: evaluate = in_window;
			default: evaluate = 1'b0;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mode_r <= TTM_OFF;
			sched_cnt_r <= '0;
		end else if (i_ce) begin
			mode_r <= mode_nxt;
			// Window restarts on each entry so a first sample is never late
			if (mode_r != TTM_SAMPLE || sched_last) begin
				sched_cnt_r <= '0;
			end else begin
				sched_cnt_r <= sched_cnt_r + 1'b1;
			end
		end
	end

	// Threshold comparisons with hysteresis and debounce
	genvar g;
	generate
		for (g = 0; g < NW; g++) begin : g_warn
			localparam logic [TW-1:0] THR = ttm_pkg::WARN_THR_C[g];
			localparam logic [TW-1:0] REL = THR - ttm_pkg::WARN_HYS_C;
			// Centre sensor only
			wire raw = warn_db_q[g] ? (i_centre_temp >= REL) : (i_centre_temp >= THR);
			ttm_debounce #(.CYC(DEBOUNCE_CYC)) u_db (
				.i_core_clk(i_core_clk),
				.i_rst_n(i_rst_n),
				.i_ce(i_ce),
				.i_run(evaluate),
				.i_raw(raw),
				.o_level(warn_db_q[g])
			);
		end
	endgenerate

	localparam logic [TW-1:0] SD_REL = ttm_pkg::SD_THR_C - ttm_pkg::SD_HYS_C;
	wire sd_raw = sd_db_q ? (i_centre_temp >= SD_REL) : (i_centre_temp >= ttm_pkg::SD_THR_C);
	ttm_debounce #(.CYC(DEBOUNCE_CYC)) u_sd_db (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_run(evaluate),
		.i_raw(sd_raw),
		.o_level(sd_db_q)
	);

	// Register decode
	wire wr_ctrl = i_wr && i_addr == ttm_pkg::REG_CTRL;
	wire wr_flag = i_wr && i_addr == ttm_pkg::REG_FLAG;
	wire wr_mask = i_wr && i_addr == ttm_pkg::REG_MASK;
	wire [NW-1:0] flag_clr = wr_flag ? i_wdata[NW-1:0] : '0;
	wire [NW-1:0] rise = warn_db_q & ~warn_db_prev_r;
	// Set wins over a same-cycle clear
	wire [NW-1:0] flag_nxt = (warn_irq_flag_r & ~flag_clr) | rise;
	wire [7:0] stat_word = {5'h00, evaluate, mode_r != TTM_OFF, sd_active_r};
	logic [7:0] rd_mux;
	always_comb begin
		case (i_addr)
			ttm_pkg::REG_CTRL: rd_mux = {6'h00, temp_monitor_always_on_r, temp_monitor_enable_r};
			ttm_pkg::REG_FLAG: rd_mux = {2'h0, warn_irq_flag_r};
			ttm_pkg::REG_MASK: rd_mux = {2'h0, warn_irq_mask_r};
			ttm_pkg::REG_LIVE: rd_mux = {2'h0, warn_live_level_r};
			ttm_pkg::REG_STAT: rd_mux = stat_word;
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			temp_monitor_enable_r <= ttm_pkg::CTRL_RST[ttm_pkg::CTRL_EN_BIT];
			temp_monitor_always_on_r <= ttm_pkg::CTRL_RST[ttm_pkg::CTRL_AON_BIT];
			warn_irq_mask_r <= ttm_pkg::MASK_RST;
			warn_irq_flag_r <= '0;
			warn_db_prev_r <= '0;
			rdata_r <= 8'h00;
		end else if (i_ce) begin
			if (wr_ctrl) begin
				temp_monitor_enable_r <= i_wdata[ttm_pkg::CTRL_EN_BIT];
				temp_monitor_always_on_r <= i_wdata[ttm_pkg::CTRL_AON_BIT];
			end
			if (wr_mask) begin
				warn_irq_mask_r <= i_wdata[NW-1:0];
			end
			warn_irq_flag_r <= flag_nxt;
			warn_db_prev_r <= warn_db_q;
			rdata_r <= i_rd ? rd_mux : 8'h00;
		end
	end

	// Live levels follow debounced state; held while monitor is off
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			warn_live_level_r <= '0;
			sd_active_r <= 1'b0;
		end else if (i_ce) begin
			warn_live_level_r <= warn_db_q;
			// Shutdown latch holds across sampling gaps until cooled
			sd_active_r <= sd_db_q;
		end
	end

	assign o_irq_out_n = ~|(warn_irq_flag_r & ~warn_irq_mask_r);
	assign o_rdata = rdata_r;
	assign o_sensor_power = mode_r == TTM_AON || (mode_r == TTM_SAMPLE && in_window);
	assign o_thermal_shutdown = sd_active_r;
endmodule

// file: tb/ttm_chk_sva.sv
`timescale 1ns/1ps
module ttm_chk #(
	parameter int WINDOW_CYC = 10
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic [8:0] i_centre_temp,
	input wire logic i_standby,
	input wire logic [3:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic o_irq_out_n,
	input wire logic o_sensor_power,
	input wire logic o_thermal_shutdown
);
	logic [7:0] hot_r;
	logic [7:0] pw_r;
	logic wrs_r;
	logic stby_r;
	// Run lengths of hot temperature and of powered standby
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hot_r <= 8'h00;
			pw_r <= 8'h00;
			wrs_r <= 1'b0;
			stby_r <= 1'b0;
		end else begin
			hot_r <= (i_centre_temp >= ttm_pkg::SD_THR_C) ? hot_r + 8'h01 : 8'h00;
			// Mode follows standby one cycle late
			stby_r <= i_standby;
			pw_r <= (o_sensor_power && i_standby && stby_r) ? pw_r + 8'h01 : 8'h00;
			wrs_r <= wrs_r | i_wr;
		end
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	property p_rd_idle;
		$past(i_ce && !i_rd) |-> o_rdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
	property p_sd_rise;
		$rose(o_thermal_shutdown) |-> hot_r >= 8'h04;
	endproperty
	a_sd_rise: assert property (p_sd_rise) else $error("early shutdown");
	property p_sd_fall;
		$fell(o_thermal_shutdown) |-> $past(i_centre_temp, 4) < 9'h09B;
	endproperty
	a_sd_fall: assert property (p_sd_fall) else $error("early restart");
	property p_stby_win;
		pw_r <= WINDOW_CYC;
	endproperty
	a_stby_win: assert property (p_stby_win) else $error("standby window long");
	property p_irq_fall;
		$fell(o_irq_out_n) |-> $past(i_wr) || $past(i_centre_temp) >= 9'h050;
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq without cause");
	property p_irq_rise;
		$rose(o_irq_out_n) |-> $past(i_wr);
	endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("irq dropped alone");
	property p_stat;
		i_rd && i_ce && i_addr == ttm_pkg::REG_STAT |=>
			{o_rdata[2], o_rdata[0]} == {$past(o_sensor_power), $past(o_thermal_shutdown)};
	endproperty
	a_stat: assert property (p_stat) else $error("stat mismatch");
	property p_irq_rst;
		!wrs_r |-> o_irq_out_n;
	endproperty
	a_irq_rst: assert property (p_irq_rst) else $error("irq while masked");
endmodule
bind ttm_monitor ttm_chk #(.WINDOW_CYC(WINDOW_CYC)) u_chk (.*);

// file: tb/ttm_host.sv
`timescale 1ns/1ps
module ttm_host (
	input wire logic i_core_clk,
	input wire logic [7:0] i_rdata,
	output logic [3:0] o_addr,
	output logic [7:0] o_wdata,
	output logic o_wr,
	output logic o_rd
);
	initial begin
		o_addr = 4'h0;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	task wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		o_wr <= 1'b1;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_core_clk);
		o_wr <= 1'b0;
		#1;
	endtask
	task rd_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge i_core_clk);
		o_rd <= 1'b1;
		o_addr <= a;
		@(posedge i_core_clk);
		o_rd <= 1'b0;
		#1 d = i_rdata;
	endtask
endmodule

// file: tb/test_thermal_threshold_monitor.sv
`timescale 1ns/1ps
module test_thermal_threshold_monitor;
	logic clk, rst_n, stby, wr, rds, irq_n, pwr, sd;
	logic ce = 1'b1;
	logic [8:0] temp;
	logic [7:0] rd, wd, rdata;
	logic [3:0] ad;
	int n_errors, samples_checked, cyc, k, cnt;
	ttm_monitor #(.DEBOUNCE_CYC(4), .WINDOW_CYC(10), .INTERVAL_CYC(40)) uut (.i_core_clk(clk),
		.i_rst_n(rst_n), .i_ce(ce), .i_centre_temp(temp), .i_standby(stby), .i_addr(ad),
		.i_wdata(wd), .i_wr(wr), .i_rd(rds), .o_rdata(rdata), .o_irq_out_n(irq_n),
		.o_sensor_power(pwr), .o_thermal_shutdown(sd));
	ttm_host host (.i_core_clk(clk), .i_rdata(rdata), .o_addr(ad), .o_wdata(wd), .o_wr(wr),
		.o_rd(rds));
	task results;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task chk(input string s, input logic [7:0] v, input logic [7:0] e);
		samples_checked++;
		if (v !== e) begin
			n_errors++;
			$display("ERROR %s exp %h got %h", s, e, v);
		end
	endtask
	task rc(input logic [3:0] a, input logic [7:0] e, input string s);
		host.rd_reg(a, rd);
		chk(s, rd, e);
	endtask
	task tw(input logic [8:0] t, input int n);
		@(posedge clk);
		temp <= t;
		repeat (n) @(posedge clk);
	endtask
	// Fixed window, so any phase holds two full sample windows
	task cp(input logic [7:0] e);
		cnt = 0;
		repeat (50) @(posedge clk);
		repeat (80) begin
			@(negedge clk);
			cnt += int'(pwr);
		end
		chk("powered", 8'(cnt), e);
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			results();
		end
	end
	initial begin
		{rst_n, stby, temp, n_errors, samples_checked, cyc} = '0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rc(ttm_pkg::REG_MASK, 8'h3F, "mask");
		rc(ttm_pkg::REG_CTRL, 8'h00, "ctrl");
		chk("pwr", 8'(pwr), 8'h00);
		host.wr_reg(ttm_pkg::REG_CTRL, 8'h03);
		rc(ttm_pkg::REG_STAT, 8'h06, "stat");
		tw(9'h050, 2);
		tw(9'h000, 8);
		rc(ttm_pkg::REG_FLAG, 8'h00, "glitch");
		for (k = 0; k < 6; k++) begin
			tw(ttm_pkg::WARN_THR_C[k], 8);
			rc(ttm_pkg::REG_LIVE, 8'((2 << k) - 1), "live");
			rc(ttm_pkg::REG_FLAG, 8'((2 << k) - 1), "flag");
		end
		chk("irq", 8'(irq_n), 8'h01);
		host.wr_reg(ttm_pkg::REG_MASK, 8'h3E);
		chk("irq", 8'(irq_n), 8'h00);
		host.wr_reg(ttm_pkg::REG_FLAG, 8'h01);
		chk("irq", 8'(irq_n), 8'h01);
		rc(ttm_pkg::REG_FLAG, 8'h3E, "flag");
		$display("test thresholds done");
		tw(9'h096, 8);
		rc(ttm_pkg::REG_LIVE, 8'h3F, "live");
		tw(9'h095, 8);
		rc(ttm_pkg::REG_LIVE, 8'h1F, "live");
		tw(9'h0A5, 8);
		chk("sd", 8'(sd), 8'h01);
		tw(9'h09C, 8);
		chk("sd", 8'(sd), 8'h01);
		tw(9'h09A, 8);
		chk("sd", 8'(sd), 8'h00);
		// Clock enable low must freeze the debounce and shutdown state
		ce <= 1'b0;
		tw(9'h0A5, 8);
		chk("frozen", 8'(sd), 8'h00);
		ce <= 1'b1;
		$display("test hysteresis done");
		tw(9'h000, 2);
		stby <= 1'b1;
		cp(8'h14);
		stby <= 1'b0;
		host.wr_reg(ttm_pkg::REG_CTRL, 8'h01);
		cp(8'h14);
		host.wr_reg(ttm_pkg::REG_CTRL, 8'h00);
		cp(8'h00);
		rc(4'hF, 8'h00, "unmapped");
		$display("test power done");
		results();
	end
endmodule
